/* tcc_pkg.sv */
// package: constants, levels and decode helpers for the cc strap and status block
package tcc_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int STRAP_LATCH_NS = 10000;
  localparam int STRAP_LATCH_CYC = (STRAP_LATCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SRC_DEF_UA = 80;
  localparam int SRC_MED_UA = 180;
  localparam int SRC_HIGH_UA = 330;

  localparam logic [7:0] REG_CTRL = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h03;
  localparam logic [7:0] REG_IRQ = 8'h04;
  localparam logic [7:0] REG_CONDET = 8'h09;
  localparam logic [7:0] REG_VCONN = 8'h0A;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CONDET_RST = 8'h01;
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_ROLE_LSB = 1;
  localparam int CTRL_RP_LSB = 3;
  localparam int CONDET_DIS_BIT = 0;
  localparam int IRQ_ATTACH = 0;
  localparam int IRQ_DETACH = 1;
  localparam int IRQ_CUR = 2;

  localparam logic [7:0] I2C_ADDR_HI = 8'h7C;
  localparam logic [7:0] I2C_ADDR_LO = 8'h3C;

  localparam logic [1:0] ROLE_SNK = 2'h0;
  localparam logic [1:0] ROLE_SRC = 2'h1;
  localparam logic [1:0] ROLE_DRP = 2'h2;
  localparam logic [1:0] CUR_DEF = 2'h0;
  localparam logic [1:0] CUR_MED = 2'h1;
  localparam logic [1:0] CUR_HIGH = 2'h2;

  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} tcc_lvl_t;

  // two comparator outputs to a three-level reading
  function automatic tcc_lvl_t lvl_of(input logic hi, input logic lo);
    if (hi) begin
      return LVL_HIGH;
    end else if (lo) begin
      return LVL_LOW;
    end
    return LVL_MID;
  endfunction

  function automatic logic [1:0] role_of(input tcc_lvl_t lvl);
    unique case (lvl)
      LVL_HIGH: return ROLE_SRC;
      LVL_LOW: return ROLE_SNK;
      LVL_MID: return ROLE_DRP;
      default: return ROLE_DRP;
    endcase
  endfunction
endpackage

/* tcc_strap_if.sv */
// interface: strap levels handed from the latch to the status logic
`timescale 1ns/1ps
interface tcc_strap_if;
  logic latched;
  tcc_pkg::tcc_lvl_t mode_lvl;
  tcc_pkg::tcc_lvl_t mode_at_latch;
  tcc_pkg::tcc_lvl_t adr_lvl;
  modport prod (output latched, output mode_lvl, output mode_at_latch, output adr_lvl);
  modport cons (input latched, input mode_lvl, input mode_at_latch, input adr_lvl);
endinterface

/* tcc_strap_latch.sv */
// module: synchronises the tri-level straps and latches them after the latch interval
`timescale 1ns/1ps
module tcc_strap_latch #(
  parameter int LATCH_CYC = tcc_pkg::STRAP_LATCH_CYC
) (
  input wire logic clk,
  input wire logic rst_sync_b,
  input wire logic port_hi,
  input wire logic port_lo,
  input wire logic adr_hi,
  input wire logic adr_lo,
  tcc_strap_if.prod sif
);
  localparam int CW = $clog2(LATCH_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(LATCH_CYC - 1);

  typedef enum logic {ST_WAIT, ST_DONE} tcc_latch_st_t;

  logic [3:0] meta_r;
  logic [3:0] pin_r;
  logic [CW-1:0] cnt_r;
  tcc_latch_st_t st_r;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      meta_r <= 4'h0;
      pin_r <= 4'h0;
    end else begin
      meta_r <= {port_hi, port_lo, adr_hi, adr_lo};
      pin_r <= meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= ST_WAIT;
      cnt_r <= '0;
      sif.mode_at_latch <= tcc_pkg::LVL_MID;
      sif.adr_lvl <= tcc_pkg::LVL_MID;
    end else begin
      unique case (st_r)
        ST_WAIT: begin
          cnt_r <= cnt_r + CW'(1);
          if (cnt_r == LAST) begin
            st_r <= ST_DONE;
            sif.mode_at_latch <= tcc_pkg::lvl_of(pin_r[3], pin_r[2]);
            sif.adr_lvl <= tcc_pkg::lvl_of(pin_r[1], pin_r[0]);
          end
        end
        ST_DONE: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

  assign sif.latched = (st_r == ST_DONE);
  assign sif.mode_lvl = tcc_pkg::lvl_of(pin_r[3], pin_r[2]);
endmodule

/* tcc_cc_strap_status.sv */
// module: strap decode, role and current selection, status registers and status pins
`timescale 1ns/1ps
module tcc_cc_strap_status #(
  parameter int LATCH_CYC = tcc_pkg::STRAP_LATCH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mode_pin_hi,
  input wire logic mode_pin_lo,
  input wire logic strap_pin_hi,
  input wire logic strap_pin_lo,
  input wire logic cc1_rd,
  input wire logic cc2_rd,
  input wire logic cc1_rp,
  input wire logic cc2_rp,
  input wire logic src_med,
  input wire logic src_high,
  input wire logic cc1_ra,
  input wire logic cc2_ra,
  input wire logic audio_det,
  input wire logic vconn1_det,
  input wire logic vconn2_det,
  input wire logic bus_power_sense,
  input wire logic sda_pin_i,
  input wire logic scl_pin_i,
  input wire logic i2c_sda_low,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic i2c_en,
  output logic [7:0] i2c_addr,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  output logic [1:0] role_sel,
  output logic [1:0] rp_sel,
  output logic connection_indicator_o,
  output logic connection_indicator_oe,
  output logic irq_n_output_o,
  output logic irq_n_output_oe,
  output logic current_code_bit0_o,
  output logic current_code_bit0_oe,
  output logic current_code_bit1_o,
  output logic current_code_bit1_oe,
  output logic otg_role_indicator_o,
  output logic otg_role_indicator_oe
);
  localparam int NS = 14;

  logic rst_meta_b;
  logic rst_sync_b;
  logic [NS-1:0] raw_meta_r;
  logic [NS-1:0] raw_r;
  logic s_rd1, s_rd2, s_rp1, s_rp2, s_med, s_high, s_ra1, s_ra2;
  logic s_audio, s_vc1, s_vc2, s_vbus;
  logic [7:0] ctrl_r;
  logic [7:0] condet_r;
  logic [2:0] irq_r;
  logic attach_r, orient_r, ra_r, audio_r;
  logic [1:0] cur_r;
  logic attach_nxt, orient_nxt;
  logic [1:0] cur_nxt;
  logic [1:0] eff_role;
  logic [2:0] irq_ev;
  logic irq_clr;
  logic standalone;
  logic wr_ok;

  tcc_strap_if sif ();

  tcc_strap_latch #(.LATCH_CYC(LATCH_CYC)) u_strap (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .port_hi(mode_pin_hi),
    .port_lo(mode_pin_lo),
    .adr_hi(strap_pin_hi),
    .adr_lo(strap_pin_lo),
    .sif(sif.prod)
  );

  // reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // analogue flags and i2c pins, two flops
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      raw_meta_r <= '0;
      raw_r <= '0;
    end else begin
      raw_meta_r <= {cc1_rd, cc2_rd, cc1_rp, cc2_rp, src_med, src_high, cc1_ra, cc2_ra,
                     audio_det, vconn1_det, vconn2_det, bus_power_sense, sda_pin_i, scl_pin_i};
      raw_r <= raw_meta_r;
    end
  end

  assign {s_rd1, s_rd2, s_rp1, s_rp2, s_med, s_high, s_ra1, s_ra2} = raw_r[13:6];
  assign {s_audio, s_vc1, s_vc2, s_vbus} = raw_r[5:2];
  assign i2c_sda_in = raw_r[1];
  assign i2c_scl_in = raw_r[0];

  // strap decode
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      i2c_en <= 1'b0;
      i2c_addr <= 8'h00;
    end else begin
      i2c_en <= sif.latched && (sif.adr_lvl != tcc_pkg::LVL_MID);
      if (sif.adr_lvl == tcc_pkg::LVL_HIGH) begin
        i2c_addr <= tcc_pkg::I2C_ADDR_HI;
      end else begin
        i2c_addr <= tcc_pkg::I2C_ADDR_LO;
      end
    end
  end

  assign standalone = sif.latched && (sif.adr_lvl == tcc_pkg::LVL_MID);
  assign wr_ok = reg_wr && i2c_en;

  // role: live pin when standalone, latched pin or override in i2c mode
  always_comb begin
    if (!i2c_en) begin
      eff_role = tcc_pkg::role_of(sif.mode_lvl);
    end else if (ctrl_r[tcc_pkg::CTRL_OVR_BIT]) begin
      eff_role = ctrl_r[tcc_pkg::CTRL_ROLE_LSB +: 2];
    end else begin
      eff_role = tcc_pkg::role_of(sif.mode_at_latch);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      role_sel <= tcc_pkg::ROLE_DRP;
      rp_sel <= tcc_pkg::CUR_DEF;
    end else begin
      role_sel <= eff_role;
      if (i2c_en) begin
        rp_sel <= ctrl_r[tcc_pkg::CTRL_RP_LSB +: 2];
      end else begin
        rp_sel <= tcc_pkg::CUR_DEF;
      end
    end
  end

  // control registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_r <= tcc_pkg::CTRL_RST;
      condet_r <= tcc_pkg::CONDET_RST;
    end else begin
      if (wr_ok && reg_addr == tcc_pkg::REG_CTRL) begin
        ctrl_r <= reg_wdata;
      end
      if (wr_ok && reg_addr == tcc_pkg::REG_CONDET) begin
        condet_r <= reg_wdata;
      end
    end
  end

  // attach, orientation, termination and current classification
  always_comb begin
    attach_nxt = ((eff_role != tcc_pkg::ROLE_SNK) && (s_rd1 || s_rd2)) ||
                 ((eff_role != tcc_pkg::ROLE_SRC) && (s_rp1 || s_rp2));
    orient_nxt = (s_rd2 || s_rp2) && !(s_rd1 || s_rp1);
    if (!(s_rp1 || s_rp2) || eff_role == tcc_pkg::ROLE_SRC) begin
      cur_nxt = tcc_pkg::CUR_DEF;
    end else if (s_high) begin
      cur_nxt = tcc_pkg::CUR_HIGH;
    end else if (s_med) begin
      cur_nxt = tcc_pkg::CUR_MED;
    end else begin
      cur_nxt = tcc_pkg::CUR_DEF;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      attach_r <= 1'b0;
      orient_r <= 1'b0;
      ra_r <= 1'b0;
      cur_r <= tcc_pkg::CUR_DEF;
      audio_r <= 1'b0;
    end else if (sif.latched) begin
      attach_r <= attach_nxt;
      orient_r <= orient_nxt;
      ra_r <= s_ra1 || s_ra2;
      cur_r <= cur_nxt;
      audio_r <= s_audio;
    end
  end

  // interrupt flags: events set, read of the flag register clears, set wins
  assign irq_ev[tcc_pkg::IRQ_ATTACH] = sif.latched && attach_nxt && !attach_r;
  assign irq_ev[tcc_pkg::IRQ_DETACH] = sif.latched && !attach_nxt && attach_r;
  assign irq_ev[tcc_pkg::IRQ_CUR] = sif.latched && (cur_nxt != cur_r);
  assign irq_clr = reg_rd && i2c_en && (reg_addr == tcc_pkg::REG_IRQ);

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_r <= 3'h0;
    end else if (irq_clr) begin
      irq_r <= irq_ev;
    end else begin
      irq_r <= irq_r | irq_ev;
    end
  end

  // register reads
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        tcc_pkg::REG_CTRL: reg_rdata <= ctrl_r;
        tcc_pkg::REG_STATUS: reg_rdata <= {s_vbus, eff_role, cur_r, ra_r, orient_r, attach_r};
        tcc_pkg::REG_IRQ: reg_rdata <= {5'h00, irq_r};
        tcc_pkg::REG_CONDET: reg_rdata <= condet_r;
        tcc_pkg::REG_VCONN: reg_rdata <= {6'h00, s_vc2, s_vc1};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // pins
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      connection_indicator_oe <= 1'b0;
      connection_indicator_o <= 1'b0;
      irq_n_output_oe <= 1'b0;
      current_code_bit0_oe <= 1'b0;
      current_code_bit1_oe <= 1'b0;
      otg_role_indicator_oe <= 1'b0;
    end else begin
      connection_indicator_oe <= standalone ||
        (sif.latched && i2c_en && !condet_r[tcc_pkg::CONDET_DIS_BIT]);
      connection_indicator_o <= attach_r;
      if (i2c_en) begin
        irq_n_output_oe <= |irq_r;
        current_code_bit0_oe <= i2c_sda_low;
        current_code_bit1_oe <= 1'b0;
      end else begin
        irq_n_output_oe <= standalone && audio_r;
        current_code_bit0_oe <= standalone && (cur_r != tcc_pkg::CUR_DEF);
        current_code_bit1_oe <= standalone && (cur_r == tcc_pkg::CUR_HIGH);
      end
      otg_role_indicator_oe <= sif.latched && (eff_role != tcc_pkg::ROLE_SNK) &&
        (s_rd1 || s_rd2);
    end
  end

  assign irq_n_output_o = 1'b0;
  assign current_code_bit0_o = 1'b0;
  assign current_code_bit1_o = 1'b0;
  assign otg_role_indicator_o = 1'b0;

  // checks
  chk_addr_high: assert property (@(posedge clk) disable iff (!rst_sync_b)
    sif.latched && sif.adr_lvl == tcc_pkg::LVL_HIGH |=> i2c_en && i2c_addr == 8'h7C)
    else $error("strap high did not give address 7C");
  chk_addr_low: assert property (@(posedge clk) disable iff (!rst_sync_b)
    sif.latched && sif.adr_lvl == tcc_pkg::LVL_LOW |=> i2c_en && i2c_addr == 8'h3C)
    else $error("strap low did not give address 3C");
  chk_strap_mid: assert property (@(posedge clk) disable iff (!rst_sync_b)
    sif.adr_lvl == tcc_pkg::LVL_MID |-> !i2c_en)
    else $error("i2c enabled with strap at mid");
  chk_condet_gate: assert property (@(posedge clk) disable iff (!rst_sync_b)
    i2c_en && condet_r[0] && $past(condet_r[0]) |-> !connection_indicator_oe)
    else $error("connection output driven while disabled");
  chk_condet_value: assert property (@(posedge clk) disable iff (!rst_sync_b)
    connection_indicator_oe && connection_indicator_o |-> $past(s_rd1 || s_rd2 || s_rp1 || s_rp2, 2))
    else $error("connection output high without a termination");
  chk_irq_attach: assert property (@(posedge clk) disable iff (!rst_sync_b)
    i2c_en && $rose(attach_r) |=> irq_n_output_oe)
    else $error("attach did not pull interrupt low");
  chk_pins_idle: assert property (@(posedge clk) disable iff (!rst_sync_b)
    !sif.latched && !$past(sif.latched) |-> !irq_n_output_oe && !connection_indicator_oe &&
      !current_code_bit0_oe && !current_code_bit1_oe && !otg_role_indicator_oe)
    else $error("open-drain output active before strap latch");
  chk_rp_standalone: assert property (@(posedge clk) disable iff (!rst_sync_b)
    !i2c_en ##1 !i2c_en |-> rp_sel == tcc_pkg::CUR_DEF)
    else $error("standalone source not at default current");
  chk_cur_code: assert property (@(posedge clk) disable iff (!rst_sync_b)
    standalone && cur_r == tcc_pkg::CUR_HIGH |=> current_code_bit0_oe && current_code_bit1_oe)
    else $error("high current code wrong");
  chk_mode_track: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (!i2c_en && sif.mode_lvl == tcc_pkg::LVL_HIGH) [*2] |-> role_sel == tcc_pkg::ROLE_SRC)
    else $error("standalone role does not follow mode pin");
  chk_role_ind: assert property (@(posedge clk) disable iff (!rst_sync_b)
    otg_role_indicator_oe |-> $past(eff_role) != tcc_pkg::ROLE_SNK)
    else $error("role indicator low while sinking");
  chk_role_pull: assert property (@(posedge clk) disable iff (!rst_sync_b)
    sif.latched && eff_role == tcc_pkg::ROLE_SRC && (s_rd1 || s_rd2) |=> otg_role_indicator_oe)
    else $error("role indicator not pulled with sink attached");
  chk_cur_med: assert property (@(posedge clk) disable iff (!rst_sync_b)
    standalone && cur_r == tcc_pkg::CUR_MED |=> current_code_bit0_oe && !current_code_bit1_oe)
    else $error("medium current code wrong");
  chk_cur_default: assert property (@(posedge clk) disable iff (!rst_sync_b)
    standalone && cur_r == tcc_pkg::CUR_DEF |=> !current_code_bit0_oe && !current_code_bit1_oe)
    else $error("default current code wrong");
  chk_audio_flag: assert property (@(posedge clk) disable iff (!rst_sync_b)
    standalone && audio_r |=> irq_n_output_oe)
    else $error("audio accessory did not pull the flag");
  chk_irq_release: assert property (@(posedge clk) disable iff (!rst_sync_b)
    i2c_en && irq_r == 3'h0 |=> !irq_n_output_oe)
    else $error("interrupt pulled with no flag set");
  chk_condet_on: assert property (@(posedge clk) disable iff (!rst_sync_b)
    i2c_en && !condet_r[tcc_pkg::CONDET_DIS_BIT] |=> connection_indicator_oe)
    else $error("connection output not enabled after clear");
  chk_rp_default: assert property (@(posedge clk) disable iff (!rst_sync_b)
    i2c_en && ctrl_r[tcc_pkg::CTRL_RP_LSB +: 2] == tcc_pkg::CUR_DEF |=> rp_sel == tcc_pkg::CUR_DEF)
    else $error("pull-up not at default current");
endmodule

/* tcc_port_partner.sv */
// port partner model: terminations and advertisement seen on the cc lines
`timescale 1ns/1ps
module tcc_port_partner (
  input wire logic clk,
  input wire logic [1:0] kind,
  input wire logic [1:0] cur,
  input wire logic flip,
  input wire logic [1:0] vconn,
  output logic cc1_rd,
  output logic cc2_rd,
  output logic cc1_rp,
  output logic cc2_rp,
  output logic src_med,
  output logic src_high,
  output logic cc1_ra,
  output logic cc2_ra,
  output logic audio_det,
  output logic vconn1_det,
  output logic vconn2_det,
  output logic bus_power_sense
);
  // kind: 0 open, 1 sink, 2 source, 3 audio accessory
  always @(posedge clk) begin
    cc1_rd <= (kind == 2'h1) && !flip;
    cc2_rd <= (kind == 2'h1) && flip;
    cc1_rp <= (kind == 2'h2) && !flip;
    cc2_rp <= (kind == 2'h2) && flip;
    src_med <= (kind == 2'h2) && (cur == 2'h1);
    src_high <= (kind == 2'h2) && (cur == 2'h2);
    cc1_ra <= (kind == 2'h3);
    cc2_ra <= (kind == 2'h3);
    audio_det <= (kind == 2'h3);
    vconn1_det <= vconn[0];
    vconn2_det <= vconn[1];
    bus_power_sense <= (kind == 2'h2);
  end
endmodule

/* test_tcc_cc_strap_status.sv */
// testbench: strap decode, status pins and registers against a rule model
`timescale 1ns/1ps
module test_tcc_cc_strap_status;
  localparam int LATCH = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic mode_pin_hi = 1'b0, mode_pin_lo = 1'b0, strap_pin_hi = 1'b0, strap_pin_lo = 1'b0;
  logic sda_pin_i = 1'b1, scl_pin_i = 1'b1, i2c_sda_low = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd, lfsr_r = 8'h2A, pq;
  logic [1:0] kind = 2'h0, cur = 2'h0, vconn = 2'h0;
  logic flip = 1'b0;
  wire cc1_rd, cc2_rd, cc1_rp, cc2_rp, src_med, src_high, cc1_ra, cc2_ra;
  wire audio_det, vconn1_det, vconn2_det, bus_power_sense;
  logic [7:0] reg_rdata, i2c_addr;
  logic [1:0] role_sel, rp_sel;
  logic i2c_en, i2c_sda_in, i2c_scl_in, con_o, con_oe, irq_o, irq_oe;
  logic b0_o, b0_oe, b1_o, b1_oe, otg_o, otg_oe;
  int miscompares = 0;
  int total_checks = 0;

  always #20 clk = ~clk;

  tcc_port_partner i_partner (.clk(clk), .kind(kind), .cur(cur), .flip(flip), .vconn(vconn),
    .cc1_rd(cc1_rd), .cc2_rd(cc2_rd), .cc1_rp(cc1_rp), .cc2_rp(cc2_rp), .src_med(src_med),
    .src_high(src_high), .cc1_ra(cc1_ra), .cc2_ra(cc2_ra), .audio_det(audio_det),
    .vconn1_det(vconn1_det), .vconn2_det(vconn2_det), .bus_power_sense(bus_power_sense));

  tcc_cc_strap_status #(.LATCH_CYC(LATCH)) i_dut (.clk(clk), .rst_b(rst_b),
    .mode_pin_hi(mode_pin_hi), .mode_pin_lo(mode_pin_lo), .strap_pin_hi(strap_pin_hi),
    .strap_pin_lo(strap_pin_lo), .cc1_rd(cc1_rd), .cc2_rd(cc2_rd), .cc1_rp(cc1_rp), .cc2_rp(cc2_rp),
    .src_med(src_med), .src_high(src_high), .cc1_ra(cc1_ra), .cc2_ra(cc2_ra), .audio_det(audio_det),
    .vconn1_det(vconn1_det), .vconn2_det(vconn2_det), .bus_power_sense(bus_power_sense),
    .sda_pin_i(sda_pin_i), .scl_pin_i(scl_pin_i), .i2c_sda_low(i2c_sda_low), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .i2c_en(i2c_en), .i2c_addr(i2c_addr), .i2c_sda_in(i2c_sda_in), .i2c_scl_in(i2c_scl_in),
    .role_sel(role_sel), .rp_sel(rp_sel), .connection_indicator_o(con_o),
    .connection_indicator_oe(con_oe), .irq_n_output_o(irq_o), .irq_n_output_oe(irq_oe),
    .current_code_bit0_o(b0_o), .current_code_bit0_oe(b0_oe), .current_code_bit1_o(b1_o),
    .current_code_bit1_oe(b1_oe), .otg_role_indicator_o(otg_o), .otg_role_indicator_oe(otg_oe));

  // rule model: role from a three-level reading, pulled code pins from a current class
  function automatic logic [7:0] exp_role(input int lvl);
    return (lvl == 2) ? 8'h01 : (lvl == 0) ? 8'h00 : 8'h02;
  endfunction
  function automatic logic [7:0] exp_code(input int c);
    return (c == 2) ? 8'h03 : (c == 1) ? 8'h01 : 8'h00;
  endfunction
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      lfsr_r = lfsr_next(lfsr_r);
      sda_pin_i = lfsr_r[0];
      scl_pin_i = lfsr_r[1];
      i2c_sda_low = lfsr_r[2];
    end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic set_mode(input int lvl);
    mode_pin_hi = (lvl == 2);
    mode_pin_lo = (lvl == 0);
  endtask
  task automatic do_reset(input int strap, input int mode);
    rst_b = 1'b0;
    kind = 2'h0;
    strap_pin_hi = (strap == 2);
    strap_pin_lo = (strap == 0);
    set_mode(mode);
    tick(10);
    chk({3'h0, con_oe, irq_oe, b0_oe, b1_oe, otg_oe}, 8'h00);
    rst_b = 1'b1;
    tick(LATCH + 6);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic reg_read(input logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    rd = reg_rdata;
    reg_rd = 1'b0;
    tick(1);
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    end_sim;
  end

  initial begin
    // standalone personality
    do_reset(1, 2);
    chk(8'(i2c_en), 8'h00);
    chk(8'(rp_sel), 8'h00);
    for (int l = 0; l < 3; l++) begin
      set_mode(l);
      tick(8);
      chk(8'(role_sel), exp_role(l));
    end
    set_mode(2);
    tick(8);
    chk(8'(role_sel), exp_role(2));
    chk(8'(con_oe), 8'h01);
    flip = lfsr_r[3];
    kind = 2'h1;
    tick(8);
    chk({6'h00, con_o, otg_oe}, 8'h03);
    kind = 2'h0;
    tick(8);
    chk({6'h00, con_o, otg_oe}, 8'h00);
    set_mode(0);
    for (int c = 0; c < 3; c++) begin
      kind = 2'h2;
      cur = 2'(c);
      tick(8);
      chk({6'h00, b1_oe, b0_oe}, exp_code(c));
    end
    kind = 2'h3;
    tick(8);
    chk(8'(irq_oe), 8'h01);
    reg_read(8'h03);
    chk(rd & 8'h04, 8'h04);
    kind = 2'h0;
    tick(8);
    chk(8'(irq_oe), 8'h00);
    $display("test standalone done");
    // register personality, strap high
    do_reset(2, 0);
    chk({i2c_en, i2c_addr[6:0]}, 8'hFC);
    chk(8'(rp_sel), 8'h00);
    pq = {5'h00, i2c_sda_low, scl_pin_i, sda_pin_i};
    tick(1);
    chk({7'h00, b0_oe}, {7'h00, pq[2]});
    tick(1);
    chk({6'h00, i2c_scl_in, i2c_sda_in}, {6'h00, pq[1:0]});
    chk({4'h0, irq_o, b0_o, b1_o, otg_o}, 8'h00);
    chk(8'(con_oe), 8'h00);
    reg_read(8'h09);
    chk(rd, 8'h01);
    set_mode(2);
    tick(8);
    chk(8'(role_sel), exp_role(0));
    for (int r = 0; r < 3; r++) begin
      reg_write(8'h02, 8'(r << 3) | 8'h03);
      tick(3);
      chk({4'h0, role_sel, rp_sel}, {6'h01, 2'(r)});
    end
    reg_write(8'h09, 8'h00);
    tick(3);
    chk(8'(con_oe), 8'h01);
    reg_read(8'h04);
    tick(3);
    chk(8'(irq_oe), 8'h00);
    vconn = lfsr_r[5:4];
    flip = lfsr_r[6];
    kind = 2'h1;
    tick(8);
    chk({6'h00, irq_oe, con_o}, 8'h03);
    reg_read(8'h03);
    chk(rd & 8'h67, {1'b0, 2'h1, 3'h0, flip, 1'b1});
    reg_read(8'h04);
    chk(rd & 8'h01, 8'h01);
    tick(3);
    chk(8'(irq_oe), 8'h00);
    reg_read(8'h0A);
    chk(rd & 8'h03, {6'h00, vconn});
    reg_read(8'h05);
    chk(rd, 8'h00);
    kind = 2'h0;
    tick(8);
    reg_read(8'h04);
    chk(rd & 8'h02, 8'h02);
    $display("test register high done");
    // register personality, strap low, mid mode pin
    do_reset(0, 1);
    chk({i2c_en, i2c_addr[6:0]}, 8'hBC);
    chk(8'(role_sel), exp_role(1));
    reg_write(8'h02, 8'h01);
    kind = 2'h2;
    cur = 2'h0;
    tick(8);
    reg_read(8'h04);
    cur = 2'h2;
    tick(8);
    reg_read(8'h04);
    chk(rd & 8'h04, 8'h04);
    $display("test register low done");
    end_sim;
  end
endmodule
